// *** shared/jsps_pkg.sv ***
// constants and types shared by the debug port mode switch block
// ==========================================================================
// Behaviour
// RQ1: capture state loads selected chain in parallel
// RQ2: shift state moves chain out tdo, in tdi
// RQ3: update state loads parallel register, otherwise held
// RQ4: reset sets pin enable, pullup, alt select
// RQ5: cleared alt select hands pins to gpio
// RQ6: alt select write needs unlock and commit
// RQ7: ten alternating switches in reset erase flash
// RQ8: probe holds reset, sends five switch pairs
// RQ9: probe may omit trailing high cycles
// RQ10: tap preamble walk enables serial wire mode
// RQ11: probe sends highs, code lsb first, highs
// RQ12: fifty high clocks reset tap and wire logic
// RQ13: already serial wire gives line reset
// RQ14: probe sends jtag code then five highs
// RQ15: already jtag gives test logic reset
// RQ16: jtag only when all pins debug function
// RQ17: chains reachable only through the test port
// RQ18: five high mode clocks force test logic reset
// RQ19: low test reset forces test logic reset
// RQ20: sample rising edge, drive tdo falling edge
// RQ21: last sixteen bits compared, jtag after reset
package jsps_pkg;

  // ========================================================================
  // tap controller states
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h2,
    TAP_CAPTURE_DR = 4'h3,
    TAP_SHIFT_DR   = 4'h4,
    TAP_EXIT1_DR   = 4'h5,
    TAP_PAUSE_DR   = 4'h6,
    TAP_EXIT2_DR   = 4'h7,
    TAP_UPDATE_DR  = 4'h8,
    TAP_SEL_IR     = 4'h9,
    TAP_CAPTURE_IR = 4'hA,
    TAP_SHIFT_IR   = 4'hB,
    TAP_EXIT1_IR   = 4'hC,
    TAP_PAUSE_IR   = 4'hD,
    TAP_EXIT2_IR   = 4'hE,
    TAP_UPDATE_IR  = 4'hF
  } jsps_tap_state_t;

  // selected data chain
  typedef enum logic [1:0] {
    CHAIN_BYPASS = 2'h0,
    CHAIN_IDENT  = 2'h1,
    CHAIN_DATA   = 2'h2
  } jsps_chain_t;

  // ========================================================================
  // instruction register
  localparam int unsigned IR_WIDTH = 4;
  localparam logic [3:0] IR_IDENT   = 4'hE;
  localparam logic [3:0] IR_BYPASS  = 4'hF;
  localparam logic [3:0] IR_DATA    = 4'hA;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ========================================================================
  // mode switch sequences
  localparam int unsigned SW_CODE_BITS = 16;
  localparam logic [15:0] SW_J2S_CODE = 16'hE79E;
  localparam logic [15:0] SW_S2J_CODE = 16'hE73C;
  localparam int unsigned HIGH_RUN_MIN = 50;
  localparam logic [5:0] HIGH_RUN_LAST = 6'h31;
  localparam logic [3:0] RECOVER_SWITCHES = 4'hA;

  // ========================================================================
  // shared pin configuration
  localparam int unsigned DBG_PINS = 5;
  localparam logic [4:0] PIN_DEN_RESET   = 5'h1F;
  localparam logic [4:0] PIN_PUR_RESET   = 5'h1F;
  localparam logic [4:0] PIN_AFSEL_RESET = 5'h1F;

endpackage

// *** shared/jsps_tap_if.sv ***
// tap state carried from the controller to the shift chains
`timescale 1ns/1ps
`default_nettype none
interface jsps_tap_if;
  import jsps_pkg::*;

  jsps_tap_state_t state;

  modport ctrl (output state);
  modport chain (input state);
endinterface
`default_nettype wire

// *** hdl/jsps_tap.sv ***
// tap controller state machine on the test clock
`timescale 1ns/1ps
`default_nettype none
module jsps_tap
  import jsps_pkg::*;
(
  input  wire logic   tck_i,
  input  wire logic   rst_n_i,
  input  wire logic   tms_i,
  input  wire logic   force_reset_i,
  jsps_tap_if.ctrl    tap
);

  jsps_tap_state_t next_state;

  // ========================================================================
  // next state from sampled mode line
  always_comb begin
    unique case (tap.state)
      TAP_RESET:      next_state = tms_i ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:       next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:     next_state = tms_i ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: next_state = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:   next_state = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:   next_state = tms_i ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:   next_state = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:   next_state = tms_i ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:  next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:     next_state = tms_i ? TAP_RESET : TAP_CAPTURE_IR; // RQ18
      TAP_CAPTURE_IR: next_state = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:   next_state = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:   next_state = tms_i ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:   next_state = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:   next_state = tms_i ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:  next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // ========================================================================
  // state register
  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap.state <= TAP_RESET; // RQ19
    end else if (force_reset_i) begin
      tap.state <= TAP_RESET; // RQ12
    end else begin
      tap.state <= next_state; // RQ20
    end
  end

endmodule
`default_nettype wire

// *** hdl/jsps_port_top.sv ***
// debug port: tap shift chains, jtag/serial wire switch, recovery, pin setup
`timescale 1ns/1ps
`default_nettype none
module jsps_port_top
  import jsps_pkg::*;
#(
  parameter int unsigned DR_WIDTH       = 32,
  // identification value is arbitrary
  parameter logic [31:0] IDENT_VALUE    = 32'h0000_0001
)(
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire logic                  tck_i,
  input  wire logic                  trst_n_i,
  input  wire logic                  tms_i,
  input  wire logic                  tdi_i,
  input  wire logic                  chip_rst_n_i,
  input  wire logic                  pin_cfg_wr_i,
  input  wire logic [DBG_PINS-1:0]   pin_cfg_den_i,
  input  wire logic [DBG_PINS-1:0]   pin_cfg_pur_i,
  input  wire logic [DBG_PINS-1:0]   pin_cfg_afsel_i,
  input  wire logic [DBG_PINS-1:0]   pin_commit_enable_i,
  input  wire logic                  pin_config_unlocked_i,
  output logic                       tdo_o,
  output logic                       tdo_oe_o,
  output logic                       swd_mode_o,
  output logic                       swd_line_reset_o,
  output logic [IR_WIDTH-1:0]        ir_o,
  output logic [DR_WIDTH-1:0]        data_update_o,
  output logic [DBG_PINS-1:0]        pin_digital_enable_o,
  output logic [DBG_PINS-1:0]        pin_pullup_enable_o,
  output logic [DBG_PINS-1:0]        pin_alt_function_select_o,
  output logic                       mass_erase_o
);

  // ========================================================================
  // functions
  function automatic jsps_chain_t chain_of(input logic [IR_WIDTH-1:0] ir);
    unique case (ir)
      IR_IDENT: chain_of = CHAIN_IDENT;
      IR_DATA:  chain_of = CHAIN_DATA;
      default:  chain_of = CHAIN_BYPASS;
    endcase
  endfunction

  // ========================================================================
  // system reset release
  logic sys_rst_meta;
  logic sys_rst_n;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_rst_meta <= 1'b0;
      sys_rst_n    <= 1'b0;
    end else begin
      sys_rst_meta <= 1'b1;
      sys_rst_n    <= sys_rst_meta;
    end
  end

  // ========================================================================
  // test clock reset: power-on or test reset, asserted at once
  logic tck_rst_raw_n;
  logic tck_rst_meta;
  logic tck_rst_n;

  assign tck_rst_raw_n = trst_n_i & nrst_i;

  always_ff @(posedge tck_i or negedge tck_rst_raw_n) begin
    if (!tck_rst_raw_n) begin
      tck_rst_meta <= 1'b0;
      tck_rst_n    <= 1'b0; // RQ19
    end else begin
      tck_rst_meta <= 1'b1;
      tck_rst_n    <= tck_rst_meta;
    end
  end

  // ========================================================================
  // pin configuration (system clock)
  logic [DBG_PINS-1:0] commit_mask;

  assign commit_mask = pin_commit_enable_i & {DBG_PINS{pin_config_unlocked_i}};

  always_ff @(posedge clk_sys_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pin_digital_enable_o      <= PIN_DEN_RESET;   // RQ4
      pin_pullup_enable_o       <= PIN_PUR_RESET;   // RQ4
      pin_alt_function_select_o <= PIN_AFSEL_RESET; // RQ4
    end else if (pin_cfg_wr_i) begin
      pin_digital_enable_o      <= pin_cfg_den_i;
      pin_pullup_enable_o       <= pin_cfg_pur_i;
      pin_alt_function_select_o <= (pin_alt_function_select_o & ~commit_mask)
                                 | (pin_cfg_afsel_i & commit_mask); // RQ6
    end
  end

  // ========================================================================
  // levels into the test clock domain
  logic pins_meta;
  logic pins_debug;
  logic chip_meta;
  logic chip_held;

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      pins_meta  <= 1'b0;
      pins_debug <= 1'b0;
      chip_meta  <= 1'b0;
      chip_held  <= 1'b0;
    end else begin
      pins_meta  <= &pin_alt_function_select_o; // RQ5
      pins_debug <= pins_meta; // RQ16
      chip_meta  <= ~chip_rst_n_i;
      chip_held  <= chip_meta;
    end
  end

  // ========================================================================
  // mode switch detection (test clock, rising edge)
  logic [SW_CODE_BITS-1:0] tms_hist;
  logic [SW_CODE_BITS-1:0] next_hist;
  logic [5:0]              high_run;
  logic                    run_full;
  logic                    armed;
  logic                    j2s_hit;
  logic                    s2j_hit;
  logic                    swd_mode;

  // first bit received ends up in bit 0
  assign next_hist = {tms_i, tms_hist[SW_CODE_BITS-1:1]}; // RQ21
  assign run_full  = tms_i && (high_run >= HIGH_RUN_LAST);
  // the tap preamble walk from reset produces this same mode bit stream
  assign j2s_hit   = armed && (next_hist == SW_J2S_CODE); // RQ10
  assign s2j_hit   = armed && (next_hist == SW_S2J_CODE);

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tms_hist <= '1;
      high_run <= 6'h00;
    end else begin
      tms_hist <= next_hist; // RQ21
      if (!tms_i) begin
        high_run <= 6'h00;
      end else if (!run_full) begin
        high_run <= high_run + 6'h01;
      end
    end
  end

  // a code only counts after a long high run, so jtag traffic cannot alias it
  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      armed <= 1'b0;
    end else if (run_full) begin
      armed <= 1'b1;
    end else if (j2s_hit || s2j_hit) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      swd_mode <= 1'b0; // RQ21
    end else if (j2s_hit) begin
      swd_mode <= 1'b1; // RQ10
    end else if (s2j_hit) begin
      swd_mode <= 1'b0;
    end
  end

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      swd_line_reset_o <= 1'b0;
    end else if (swd_mode && run_full) begin
      swd_line_reset_o <= 1'b1; // RQ12 RQ13
    end else if (!tms_i || !swd_mode) begin
      swd_line_reset_o <= 1'b0;
    end
  end

  assign swd_mode_o = swd_mode;

  // ========================================================================
  // recovery: ten alternating switches while the chip is held in reset
  logic [3:0] rec_count;
  logic [3:0] next_rec_count;
  logic       expect_s2j;
  logic       erase_toggle;

  assign next_rec_count = rec_count + 4'h1;

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      rec_count    <= 4'h0;
      expect_s2j   <= 1'b0;
      erase_toggle <= 1'b0;
    end else if (!chip_held) begin
      rec_count  <= 4'h0;
      expect_s2j <= 1'b0;
    end else if ((j2s_hit && !expect_s2j) || (s2j_hit && expect_s2j)) begin
      expect_s2j <= ~expect_s2j;
      if (next_rec_count == RECOVER_SWITCHES) begin
        rec_count    <= 4'h0;
        erase_toggle <= ~erase_toggle; // RQ7
      end else begin
        rec_count <= next_rec_count; // RQ7
      end
    end else if (j2s_hit) begin
      rec_count  <= 4'h1;
      expect_s2j <= 1'b1;
    end else if (s2j_hit) begin
      rec_count  <= 4'h0;
      expect_s2j <= 1'b0;
    end
  end

  // erase request crosses as a toggle; erase_seen is the edge reference
  logic erase_meta;
  logic erase_sync;
  logic erase_seen;

  always_ff @(posedge clk_sys_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      erase_meta   <= 1'b0;
      erase_sync   <= 1'b0;
      erase_seen   <= 1'b0;
      mass_erase_o <= 1'b0;
    end else begin
      erase_meta   <= erase_toggle;
      erase_sync   <= erase_meta;
      erase_seen   <= erase_sync;
      mass_erase_o <= erase_sync ^ erase_seen; // RQ7
    end
  end

  // ========================================================================
  // tap controller
  jsps_tap_if tap_bus ();
  logic       force_tlr;

  // jtag is held off in serial wire mode and while pins serve as gpio
  assign force_tlr = run_full || swd_mode || !pins_debug; // RQ12 RQ15 RQ16

  jsps_tap i_jsps_tap (
    .tck_i         (tck_i),
    .rst_n_i       (tck_rst_n),
    .tms_i         (tms_i),
    .force_reset_i (force_tlr),
    .tap           (tap_bus.ctrl)
  );

  // ========================================================================
  // shift chains; only reachable serially, nothing is bus mapped
  logic [IR_WIDTH-1:0] ir_shift;
  logic [DR_WIDTH-1:0] dr_shift;
  jsps_chain_t         chain;

  assign chain = chain_of(ir_o);

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_shift <= IR_CAPTURE;
      ir_o     <= IR_IDENT; // RQ19
    end else begin
      unique case (tap_bus.state)
        TAP_RESET:      ir_o     <= IR_IDENT; // RQ18
        TAP_CAPTURE_IR: ir_shift <= IR_CAPTURE; // RQ1
        TAP_SHIFT_IR:   ir_shift <= {tdi_i, ir_shift[IR_WIDTH-1:1]}; // RQ2
        TAP_UPDATE_IR:  ir_o     <= ir_shift; // RQ3
        default:        ir_shift <= ir_shift;
      endcase
    end
  end

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      dr_shift <= '0;
    end else if (tap_bus.state == TAP_CAPTURE_DR) begin
      unique case (chain)
        CHAIN_IDENT: dr_shift <= IDENT_VALUE[DR_WIDTH-1:0]; // RQ1
        CHAIN_DATA:  dr_shift <= data_update_o; // RQ1 RQ17
        default:     dr_shift <= '0; // RQ1
      endcase
    end else if (tap_bus.state == TAP_SHIFT_DR) begin
      if (chain == CHAIN_BYPASS) begin
        dr_shift[0] <= tdi_i; // RQ2
      end else begin
        dr_shift <= {tdi_i, dr_shift[DR_WIDTH-1:1]}; // RQ2
      end
    end
  end

  always_ff @(posedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      data_update_o <= '0;
    end else if (tap_bus.state == TAP_UPDATE_DR && chain == CHAIN_DATA) begin
      data_update_o <= dr_shift; // RQ3
    end
  end

  // ========================================================================
  // test data out on the falling edge, driven only while shifting
  always_ff @(negedge tck_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o    <= (tap_bus.state == TAP_SHIFT_IR) ? ir_shift[0] : dr_shift[0]; // RQ20
      tdo_oe_o <= (tap_bus.state == TAP_SHIFT_IR) || (tap_bus.state == TAP_SHIFT_DR);
    end
  end

endmodule
`default_nettype wire

// *** dv/jsps_port_sva.sv ***
// assertions on the ports of the debug port mode switch block
`timescale 1ns/1ps
`default_nettype none
module jsps_port_sva
  import jsps_pkg::*;
(
  input wire logic                clk_sys_i,
  input wire logic                nrst_i,
  input wire logic                tck_i,
  input wire logic                trst_n_i,
  input wire logic                tms_i,
  input wire logic                pin_cfg_wr_i,
  input wire logic [DBG_PINS-1:0] pin_cfg_afsel_i,
  input wire logic [DBG_PINS-1:0] pin_commit_enable_i,
  input wire logic                pin_config_unlocked_i,
  input wire logic                tdo_oe_o,
  input wire logic                swd_mode_o,
  input wire logic                swd_line_reset_o,
  input wire logic [IR_WIDTH-1:0] ir_o,
  input wire logic [DBG_PINS-1:0] pin_alt_function_select_o,
  input wire logic                mass_erase_o
);
  // ======================================
  // tms history, first sampled bit ends in bit 0
  logic [15:0] hist;

  always_ff @(posedge tck_i) begin
    hist <= {tms_i, hist[15:1]};
  end

  // ======================================
  // system clock side
  a_pin_reset_dflt: assert property (@(posedge clk_sys_i)
    !nrst_i |=> pin_alt_function_select_o == PIN_AFSEL_RESET)
    else $error("afsel not at default in reset");
  a_afsel_locked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pin_cfg_wr_i && !pin_config_unlocked_i |=> $stable(pin_alt_function_select_o))
    else $error("afsel changed while locked");
  a_afsel_commit: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pin_cfg_wr_i && pin_config_unlocked_i |=> pin_alt_function_select_o ==
      (($past(pin_alt_function_select_o) & ~$past(pin_commit_enable_i)) |
       ($past(pin_cfg_afsel_i) & $past(pin_commit_enable_i))))
    else $error("afsel commit mismatch");
  a_erase_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    mass_erase_o |=> !mass_erase_o)
    else $error("erase pulse too long");

  // ======================================
  // test clock side
  a_trst_default: assert property (@(posedge tck_i)
    !trst_n_i |=> ir_o == IR_IDENT && !swd_mode_o)
    else $error("test reset did not reset tap");
  a_tms_high_reset: assert property (@(posedge tck_i)
    disable iff (!trst_n_i || !nrst_i)
    tms_i [*7] |-> ir_o == IR_IDENT && !tdo_oe_o)
    else $error("high mode run did not reset tap");
  a_shift_exit: assert property (@(posedge tck_i) disable iff (!trst_n_i || !nrst_i)
    tdo_oe_o |=> tdo_oe_o == !$past(tms_i))
    else $error("shift state drive enable wrong");
  a_swd_enter: assert property (@(posedge tck_i) disable iff (!trst_n_i || !nrst_i)
    $rose(swd_mode_o) |-> hist == SW_J2S_CODE)
    else $error("serial wire mode without its code");
  a_jtag_enter: assert property (@(posedge tck_i) disable iff (!trst_n_i || !nrst_i)
    $fell(swd_mode_o) |-> hist == SW_S2J_CODE)
    else $error("jtag mode without its code");
  a_lreset_cause: assert property (@(posedge tck_i) disable iff (!trst_n_i || !nrst_i)
    $rose(swd_line_reset_o) |-> swd_mode_o && $past(tms_i) && $past(tms_i, 50))
    else $error("line reset without fifty highs");
  a_lreset_clear: assert property (@(posedge tck_i) disable iff (!trst_n_i || !nrst_i)
    swd_line_reset_o && !tms_i |=> !swd_line_reset_o)
    else $error("line reset held past low bit");
endmodule
`default_nettype wire

// *** dv/jsps_probe.sv ***
// debug probe model: test clock, mode/data and reset lines
`timescale 1ns/1ps
`default_nettype none
module jsps_probe
  import jsps_pkg::*;
(
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  output logic      chip_rst_n_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // released data output reads as the pull-up level
  wire logic line = tdo_oe_i ? tdo_i : 1'b1;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b0;
    chip_rst_n_o = 1'b1;
  end

  always #80 tck_o = ~tck_o;

  // ======================================
  // line tasks
  task automatic step(input logic m, input logic di, output logic o);
    @(negedge tck_o);
    tms_o <= m;
    tdi_o <= di;
    @(posedge tck_o);
    o = line;
  endtask

  task automatic idle(input int n);
    logic o;
    repeat (n) step(1'b1, 1'b1, o);
  endtask

  task automatic sw(input logic [15:0] code, input int lead, input int tail);
    logic o;
    idle(lead);
    for (int i = 0; i < 16; i++) step(code[i], 1'b1, o);
    idle(tail);
  endtask

  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    logic o;
    q = '0;
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  task automatic reset_tap();
    @(negedge tck_o);
    trst_n_o <= 1'b0;
    @(negedge tck_o);
    trst_n_o <= 1'b1;
    idle(6);
  endtask

  // trailing highs left out, as recovery allows
  task automatic recover();
    @(negedge tck_o);
    chip_rst_n_o <= 1'b0;
    repeat (5) begin
      sw(SW_J2S_CODE, HIGH_RUN_MIN, 0);
      sw(SW_S2J_CODE, HIGH_RUN_MIN, 0);
    end
    @(negedge tck_o);
    chip_rst_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** dv/jsps_port_top_tb.sv ***
// self-checking bench for the debug port mode switch block
`timescale 1ns/1ps
`default_nettype none
module jsps_port_top_tb;
  import jsps_pkg::*;
  typedef struct {int k; logic [31:0] v;} jsps_note_t;
  localparam logic [31:0] IDV = 32'h0000_0001; // arbitrary value
  logic             clk_sys_i = 1'b0;
  logic             nrst_i = 1'b0;
  logic             pin_cfg_wr_i = 1'b0;
  logic [4:0]       pin_cfg_den_i = 5'h1F;
  logic [4:0]       pin_cfg_pur_i = 5'h1F;
  logic [4:0]       pin_cfg_afsel_i = 5'h1F;
  logic [4:0]       pin_commit_enable_i = 5'h00;
  logic             pin_config_unlocked_i = 1'b0;
  wire logic        tck_i, tms_i, tdi_i, trst_n_i, chip_rst_n_i;
  wire logic        tdo_o, tdo_oe_o, swd_mode_o, swd_line_reset_o, mass_erase_o;
  wire logic [3:0]  ir_o;
  wire logic [31:0] data_update_o;
  wire logic [4:0]  pin_digital_enable_o, pin_pullup_enable_o, pin_alt_function_select_o;
  jsps_note_t       notes[$];
  event             smp;
  int               n_errors = 0;
  int               comparisons = 0;
  int               n_erase = 0;
  logic [31:0]      seed = 32'h0000_0037;
  logic [31:0]      q, w, v, d;

  always #2 clk_sys_i = ~clk_sys_i;

  jsps_port_top #(.IDENT_VALUE(IDV)) i_jsps_port_top (.clk_sys_i, .nrst_i, .tck_i, .trst_n_i,
    .tms_i, .tdi_i, .chip_rst_n_i, .pin_cfg_wr_i, .pin_cfg_den_i, .pin_cfg_pur_i,
    .pin_cfg_afsel_i, .pin_commit_enable_i, .pin_config_unlocked_i, .tdo_o, .tdo_oe_o,
    .swd_mode_o, .swd_line_reset_o, .ir_o, .data_update_o, .pin_digital_enable_o,
    .pin_pullup_enable_o, .pin_alt_function_select_o, .mass_erase_o);
  jsps_probe i_jsps_probe (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i),
    .chip_rst_n_o(chip_rst_n_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));

  // ======================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] obs(input int k);
    case (k)
      0: return {28'h0, ir_o};
      1: return data_update_o;
      2: return {31'h0, swd_mode_o};
      3: return {31'h0, swd_line_reset_o};
      4: return {27'h0, pin_alt_function_select_o};
      5: return {27'h0, pin_digital_enable_o};
      6: return {27'h0, pin_pullup_enable_o};
      7: return 32'(n_erase);
      default: return q;
    endcase
  endfunction

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, want, seen);
    end
  endtask

  task automatic exp(input int k, input logic [31:0] val);
    notes.push_back('{k, val});
    @(negedge clk_sys_i);
    -> smp;
  endtask

  task automatic wcfg(input logic [4:0] a, input logic [4:0] c, input logic u);
    d = xs();
    @(negedge clk_sys_i);
    pin_cfg_wr_i <= 1'b1;
    pin_cfg_den_i <= d[4:0];
    pin_cfg_pur_i <= d[9:5];
    pin_cfg_afsel_i <= a;
    pin_commit_enable_i <= c;
    pin_config_unlocked_i <= u;
    @(negedge clk_sys_i);
    pin_cfg_wr_i <= 1'b0;
    exp(5, {27'h0, d[4:0]});
    exp(6, {27'h0, d[9:5]});
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ======================================
  // result watcher
  string nm[9] = '{"ir", "update", "swd", "lreset", "afsel", "den", "pur", "erase", "tdo"};
  always begin
    @(smp);
    while (notes.size() > 0) begin
      jsps_note_t n;
      n = notes.pop_front();
      check(nm[n.k], obs(n.k), n.v);
    end
  end

  always @(posedge clk_sys_i) begin
    if (mass_erase_o === 1'b1)
      n_erase <= n_erase + 1;
  end

  initial begin
    #390000;
    n_errors++;
    final_report();
  end

  // ======================================
  // scenarios
  initial begin
    repeat (10) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    i_jsps_probe.reset_tap();
    exp(0, {28'h0, IR_IDENT});
    exp(2, 32'h0);
    exp(4, 32'h1F);
    exp(5, 32'h1F);
    exp(6, 32'h1F);
    i_jsps_probe.scan(1'b0, 32, xs(), q);
    exp(8, IDV);
    $display("defaults done");
    i_jsps_probe.scan(1'b1, 4, {28'h0, IR_DATA}, q);
    exp(8, {28'h0, IR_CAPTURE});
    exp(0, {28'h0, IR_DATA});
    w = xs();
    v = xs();
    i_jsps_probe.scan(1'b0, 32, w, q);
    exp(1, w);
    i_jsps_probe.scan(1'b0, 32, v, q);
    exp(8, w);
    exp(1, v);
    i_jsps_probe.scan(1'b1, 4, {28'h0, IR_BYPASS}, q);
    i_jsps_probe.idle(5);
    exp(0, {28'h0, IR_IDENT});
    i_jsps_probe.scan(1'b1, 4, {28'h0, IR_BYPASS}, q);
    exp(0, {28'h0, IR_BYPASS});
    i_jsps_probe.reset_tap();
    exp(0, {28'h0, IR_IDENT});
    $display("chains done");
    wcfg(5'h00, 5'h1F, 1'b0);
    exp(4, 32'h1F);
    wcfg(5'h00, 5'h1F, 1'b1);
    exp(4, 32'h00);
    i_jsps_probe.idle(4);
    i_jsps_probe.scan(1'b1, 4, {28'h0, IR_DATA}, q);
    exp(8, 32'hF);
    exp(0, {28'h0, IR_IDENT});
    w = xs();
    wcfg(5'h1F, w[4:0], 1'b1);
    exp(4, {27'h0, w[4:0]});
    wcfg(5'h1F, 5'h1F, 1'b1);
    i_jsps_probe.idle(4);
    i_jsps_probe.scan(1'b1, 4, {28'h0, IR_DATA}, q);
    exp(0, {28'h0, IR_DATA});
    $display("pins done");
    i_jsps_probe.sw(SW_J2S_CODE, HIGH_RUN_MIN, 0);
    exp(2, 32'h1);
    exp(0, {28'h0, IR_IDENT});
    i_jsps_probe.idle(HIGH_RUN_MIN);
    exp(3, 32'h1);
    i_jsps_probe.sw(SW_S2J_CODE, HIGH_RUN_MIN, 5);
    exp(2, 32'h0);
    exp(3, 32'h0);
    i_jsps_probe.sw(SW_J2S_CODE, 0, 5);
    exp(2, 32'h0);
    $display("switch done");
    exp(7, 32'h0);
    i_jsps_probe.recover();
    for (int i = 0; i < 100 && n_erase == 0; i++) @(negedge clk_sys_i);
    if (n_erase == 0) begin
      n_errors++;
      final_report();
    end
    exp(7, 32'h1);
    $display("recovery done");
    final_report();
  end
endmodule

bind jsps_port_top jsps_port_sva i_jsps_port_sva (.clk_sys_i, .nrst_i, .tck_i, .trst_n_i,
  .tms_i, .pin_cfg_wr_i, .pin_cfg_afsel_i, .pin_commit_enable_i, .pin_config_unlocked_i,
  .tdo_oe_o, .swd_mode_o, .swd_line_reset_o, .ir_o, .pin_alt_function_select_o,
  .mass_erase_o);
`default_nettype wire
